/* design/fscc_counter.sv */
`timescale 1ns/1ns
// saturating-free 8-bit cycle counter with synchronous clear
module fscc_counter
    import fscc_pkg::*;
#(
    parameter int WIDTH = FSCC_COUNT_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic incr,
    output logic [WIDTH-1:0] count
);
    // refuse a counter with no bits at elaboration
    if (WIDTH < 1) begin : g_width_check
        $error("width must be at least one");
    end

    // clear wins so a new sequence never inherits an old tally
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (incr) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule // fscc_counter

/* design/fscc_cycle_counter.sv */
`timescale 1ns/1ns
// tallies error-free difference cycles of the automatic sequences
module fscc_cycle_counter
    import fscc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic seq_start,
    input wire logic seq_sel_second,
    input wire logic [7:0] target_cycles,
    input wire logic diff_cycle_end,
    input wire logic diff_cycle_error,
    input wire logic done_clear,
    input wire logic done_irq_enable,
    input wire logic [7:0] read_addr,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    output logic read_hit,
    output logic sequence_done_flag,
    output logic irq_out,
    output logic seq_busy,
    output logic [7:0] flow_cycle_count,
    output logic sum_accumulate
);
    fscc_state_type state_q;
    logic [7:0] attempts_q;
    logic [7:0] target_q;
    logic done_flag_q;
    logic [7:0] read_data_q;
    logic good_cycle;
    logic last_attempt;
    logic finish_hit;
    logic [7:0] target_next;
    logic [7:0] status_byte;

    assign good_cycle = (state_q == FSCC_RUN) && diff_cycle_end && !diff_cycle_error;
    // the same strobe feeds the averaging adder so divisor and sum agree
    // divisor tracks sum
    assign sum_accumulate = good_cycle;
    // done is judged on attempts, so an errored last cycle still ends the run
    assign last_attempt = (attempts_q + 8'h01) >= target_q;
    assign finish_hit = (state_q == FSCC_RUN) && diff_cycle_end && last_attempt;
    // a zero target would fail the attempt bound, so it is run as a single cycle
    assign target_next = (target_cycles == 8'h00) ? FSCC_TARGET_RESET : target_cycles;

    fscc_counter #(.WIDTH(FSCC_COUNT_W)) u_count (
        .clk(clk),
        .reset(reset),
        .clear(seq_start),
        .incr(good_cycle),
        .count(flow_cycle_count)
    );

    // sequence progress counts every attempt, good or errored
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= FSCC_IDLE;
            attempts_q <= 8'h00;
            target_q <= FSCC_TARGET_RESET;
        end else begin
            case (state_q)
                FSCC_IDLE, FSCC_DONE: begin
                    if (seq_start) begin
                        state_q <= FSCC_RUN;
                        attempts_q <= 8'h00;
                        target_q <= target_next;
                    end
                end
                FSCC_RUN: begin
                    if (seq_start) begin
                        // a start while running begins afresh with the new target;
                        // the counter clears on the same strobe, so both restart together
                        attempts_q <= 8'h00;
                        target_q <= target_next;
                    end else if (diff_cycle_end) begin
                        attempts_q <= attempts_q + 8'h01;
                        if (last_attempt) begin
                            state_q <= FSCC_DONE;
                        end
                    end
                end
                default: state_q <= FSCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_flag_q <= 1'b0;
        end else if (finish_hit) begin
            done_flag_q <= 1'h1; // set beats a same-cycle clear
        end else if (done_clear) begin
            done_flag_q <= 1'b0;
        end
    end
    assign sequence_done_flag = done_flag_q;
    assign irq_out = done_flag_q && done_irq_enable;
    assign seq_busy = (state_q == FSCC_RUN);

    assign status_byte = flow_cycle_count[FSCC_COUNT_MSB:0];

    // unmapped addresses read as zero so a stray read never shows stale data
    // status byte layout
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            read_data_q <= FSCC_COUNT_RESET;
        end else if (read_strobe) begin
            read_data_q <= (read_addr == FSCC_COUNT_ADDR) ? status_byte : 8'h00;
        end
    end
    assign read_data = read_data_q;
    assign read_hit = read_strobe && (read_addr == FSCC_COUNT_ADDR);

    // checks sample at each rising edge; reset drops every attempt in flight,
    // so a reset in mid-sequence cannot raise a false alarm

    sequence s_good;
        good_cycle;
    endsequence

    // start strobe followed one edge later by a running, empty count
    sequence s_start_run;
        seq_start ##1 (seq_busy && flow_cycle_count == FSCC_COUNT_RESET);
    endsequence

    // last attempt of a run that is not being restarted at the same edge
    sequence s_last_cycle;
        finish_hit && !seq_start;
    endsequence

    a_count_incr: assert property (@(posedge clk) disable iff (reset)
        s_good and !seq_start |=> flow_cycle_count == $past(flow_cycle_count) + 8'h01)
        else $error("count did not increment");

    a_error_hold: assert property (@(posedge clk) disable iff (reset)
        diff_cycle_end && diff_cycle_error && !seq_start |=> $stable(flow_cycle_count))
        else $error("errored cycle changed count");

    a_first_seq_count: assert property (@(posedge clk) disable iff (reset)
        good_cycle && !seq_start && !seq_sel_second
            |=> flow_cycle_count == $past(flow_cycle_count) + 8'h01)
        else $error("first sequence cycle not counted");

    a_second_seq_count: assert property (@(posedge clk) disable iff (reset)
        good_cycle && !seq_start && seq_sel_second
            |=> flow_cycle_count == $past(flow_cycle_count) + 8'h01)
        else $error("second sequence cycle not counted");

    a_idle_no_count: assert property (@(posedge clk) disable iff (reset)
        !seq_busy && !seq_start |=> $stable(flow_cycle_count))
        else $error("count moved outside a run");

    a_start_clear: assert property (@(posedge clk) disable iff (reset)
        seq_start |=> flow_cycle_count == 8'h00)
        else $error("count not cleared on start");

    a_start_run: assert property (@(posedge clk) disable iff (reset)
        seq_start |-> s_start_run)
        else $error("start did not begin an empty run");

    a_done_set: assert property (@(posedge clk) disable iff (reset)
        finish_hit |=> sequence_done_flag)
        else $error("done flag not set");

    a_run_ends: assert property (@(posedge clk) disable iff (reset)
        s_last_cycle |=> !seq_busy && sequence_done_flag)
        else $error("run did not end at its target");

    a_attempt_bound: assert property (@(posedge clk) disable iff (reset)
        seq_busy |-> attempts_q < target_q)
        else $error("attempts reached target while running");

    a_flag_hold: assert property (@(posedge clk) disable iff (reset)
        sequence_done_flag && !done_clear |=> sequence_done_flag)
        else $error("done flag dropped without a clear");

    a_flag_clear: assert property (@(posedge clk) disable iff (reset)
        done_clear && !finish_hit |=> !sequence_done_flag)
        else $error("done flag survived a clear");

    a_irq_gate: assert property (@(posedge clk) disable iff (reset)
        irq_out == (sequence_done_flag && done_irq_enable))
        else $error("interrupt gating wrong");

    a_read_value: assert property (@(posedge clk) disable iff (reset)
        read_hit |=> read_data == $past(flow_cycle_count))
        else $error("status read wrong");

    a_miss_zero: assert property (@(posedge clk) disable iff (reset)
        read_strobe && !read_hit |=> read_data == 8'h00)
        else $error("unmapped read not zero");

    a_data_stands: assert property (@(posedge clk) disable iff (reset)
        !read_strobe |=> $stable(read_data))
        else $error("read data moved without a strobe");

    a_sum_pair: assert property (@(posedge clk) disable iff (reset)
        sum_accumulate && !seq_start |=> flow_cycle_count != $past(flow_cycle_count))
        else $error("sum without count");

    a_sum_quiet: assert property (@(posedge clk) disable iff (reset)
        !seq_busy |-> !sum_accumulate)
        else $error("sum strobe outside a run");

    a_count_bound: assert property (@(posedge clk) disable iff (reset)
        state_q == FSCC_DONE |-> flow_cycle_count <= target_q)
        else $error("count above target");
endmodule // fscc_cycle_counter

/* design/fscc_pkg.sv */
// Summary of operation
// - count is unsigned 8-bit binary, MSB at bit 7 of status register.
// - only valid error-free cycles of either sequence command are counted.
// - count equals number of difference results summed for averaging.
// - increment by one per error-free difference command of either sequence.
// - configured cycles done sets done flag; interrupt pin only if enabled.
package fscc_pkg;
    localparam logic [7:0] FSCC_COUNT_ADDR = 8'hE4;
    localparam int FSCC_COUNT_W = 8;
    localparam int FSCC_COUNT_MSB = 7;
    localparam logic [7:0] FSCC_COUNT_RESET = 8'h00;
    localparam logic [7:0] FSCC_TARGET_RESET = 8'h01;
    typedef enum logic [1:0] {FSCC_IDLE, FSCC_RUN, FSCC_DONE} fscc_state_type;
endpackage

/* testbench/fscc_host.sv */
`timescale 1ns/1ns
// host side: reads the status count over the read port
module fscc_host (
    input wire logic clk,
    output logic [7:0] read_addr,
    output logic read_strobe,
    input wire logic [7:0] read_data
);
    initial begin
        read_addr = 8'h00;
        read_strobe = 1'b0;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk) read_addr = a;
        read_strobe = 1'b1;
        @(negedge clk) read_strobe = 1'b0;
        read_addr = ~a;
        @(negedge clk) d = read_data;
    endtask
endmodule // fscc_host

/* testbench/test_flow_sequence_cycle_counter.sv */
`timescale 1ns/1ns
module test_flow_sequence_cycle_counter;
    import fscc_pkg::*;
    logic clk = 0, reset = 1, seq_start = 0, sel = 0, dend = 0, derr = 0, dclr = 0, ien = 1;
    logic [7:0] tgt = 8'h00, ra, rd, cnt, d;
    logic hit, flag, irq, busy, acc;
    int error_cnt = 0, check_count = 0;
    logic rs;
    fscc_host host (.clk(clk), .read_addr(ra), .read_strobe(rs), .read_data(rd));
    fscc_cycle_counter DUT (.clk(clk), .reset(reset), .seq_start(seq_start),
        .seq_sel_second(sel), .target_cycles(tgt), .diff_cycle_end(dend),
        .diff_cycle_error(derr), .done_clear(dclr), .done_irq_enable(ien),
        .read_addr(ra), .read_strobe(rs), .read_data(rd), .read_hit(hit),
        .sequence_done_flag(flag), .irq_out(irq), .seq_busy(busy),
        .flow_cycle_count(cnt), .sum_accumulate(acc));
    // 100 ns period
    always #50 clk = ~clk;
    task chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // read through the host model; the hit is looked at while the strobe stands
    task read_check(input logic [7:0] a, input logic [7:0] e, input logic h);
        fork
            host.rd(a, d);
            begin
                @(negedge clk);
                #10 chk({7'h00, hit}, {7'h00, h});
            end
        join
        chk(d, e);
    endtask
    // one difference cycle, accumulate pulse seen while it ends
    task ev(input logic e);
        @(negedge clk) dend = 1'b1;
        derr = e;
        #10 chk({7'h00, acc}, {7'h00, !e});
        @(negedge clk) dend = 1'b0;
        derr = 1'b0;
    endtask
    task st(input logic [7:0] t);
        @(negedge clk) seq_start = 1'b1;
        tgt = t;
        @(negedge clk) seq_start = 1'b0;
    endtask
    task t_errored;
        st(8'h03);
        chk({7'h00, busy}, 8'h01);
        ev(1'b0);
        ev(1'b1);
        ev(1'b0);
        chk(cnt, 8'h02);
        chk({7'h00, busy}, 8'h00);
        chk({6'h00, flag, irq}, 8'h03);
        host.rd(FSCC_COUNT_ADDR, d);
        chk(d, 8'h02);
        host.rd(8'hE5, d);
        chk(d, 8'h00);
    endtask
    task t_restart;
        @(negedge clk) ien = 1'b0;
        sel = 1'b1;
        dclr = 1'b1;
        #10 chk({7'h00, irq}, 8'h00);
        st(8'h01);
        dclr = 1'b0;
        chk(cnt, 8'h00);
        ev(1'b0);
        chk(cnt, 8'h01);
        chk({6'h00, flag, irq}, 8'h02);
    endtask
    // zero target runs one cycle; an errored one leaves the count short
    task t_zero_target;
        @(negedge clk) dclr = 1'b1;
        @(negedge clk) dclr = 1'b0;
        chk({7'h00, flag}, 8'h00);
        st(8'h00);
        chk({7'h00, busy}, 8'h01);
        ev(1'b1);
        chk(cnt, 8'h00);
        chk({6'h00, flag, busy}, 8'h02);
        @(negedge clk) dend = 1'b1;
        #10 chk({7'h00, acc}, 8'h00);
        @(negedge clk) dend = 1'b0;
        chk(cnt, 8'h00);
    endtask
    // a start while running begins afresh: count and attempts both restart
    task t_mid_restart;
        @(negedge clk) ien = 1'b1;
        sel = 1'b0;
        dclr = 1'b1;
        st(8'h02);
        dclr = 1'b0;
        ev(1'b0);
        chk(cnt, 8'h01);
        st(8'h02);
        chk(cnt, 8'h00);
        ev(1'b0);
        chk({6'h00, flag, busy}, 8'h01);
        ev(1'b1);
        chk(cnt, 8'h01);
        chk({6'h00, flag, irq}, 8'h03);
        read_check(FSCC_COUNT_ADDR, 8'h01, 1'b1);
        read_check(8'hE5, 8'h00, 1'b0);
    endtask
    // reset in mid-sequence drops count, flag, progress and read data at once
    task t_reset;
        st(8'h05);
        ev(1'b0);
        @(negedge clk) reset = 1'b1;
        @(negedge clk) reset = 1'b0;
        chk(cnt, FSCC_COUNT_RESET);
        chk({5'h00, flag, irq, busy}, 8'h00);
        chk(rd, FSCC_COUNT_RESET);
    endtask
    task finish_test;
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        t_errored();
        t_restart();
        t_zero_target();
        t_mid_restart();
        t_reset();
        finish_test();
    end
    // tests take well under a hundred cycles
    initial begin
        #200000 error_cnt++;
        finish_test();
    end
endmodule // test_flow_sequence_cycle_counter
